// File: hcd_top.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module hcd_top import hcd_pkg::*; #(
  parameter int OSC_DIVIDE = OSC_DIV,
  parameter int BLANK_CYC = BLANK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [4:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic standby_n_i,
  input wire logic thermal_trip_i,
  input wire logic overcurrent_trip_i,
  input wire logic [1:0] phase_i,
  input wire logic [1:0] current_limit_threshold_i,
  output logic [1:0] high_side_one_o,
  output logic [1:0] low_side_one_o,
  output logic [1:0] high_side_two_o,
  output logic [1:0] low_side_two_o,
  output logic irq_o
);

  logic [1:0] ctrl_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_en_reg;
  logic thermal_reg;
  logic overcurrent_reg;
  logic [3:0] osc_cnt_reg;
  logic osc_tick_reg;
  logic [4:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] hit;
  logic [1:0] run;
  logic [1:0] mode [2];
  logic aw_have;
  logic w_have;
  logic wr_fire;
  logic [3:0] irq_clr;
  logic [3:0] irq_set;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic known_addr(input logic [4:0] addr);
    return addr == REG_CTRL || addr == REG_STATUS || addr == REG_IRQ_STAT ||
           addr == REG_IRQ_EN || addr == REG_IRQ_CLR;
  endfunction

  function automatic logic [3:0] low_nibble(input logic [31:0] data, input logic [3:0] strb);
    return strb[0] ? data[3:0] : 4'h0;
  endfunction

  // ****************************************
  // Oscillator divider
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !standby_n_i) begin
      osc_cnt_reg <= 4'h0;
      osc_tick_reg <= 1'b0;
    end else if (osc_cnt_reg == 4'(OSC_DIVIDE - 1)) begin
      osc_cnt_reg <= 4'h0;
      osc_tick_reg <= 1'b1;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
      osc_tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // Fault latches
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      thermal_reg <= 1'b0;
      overcurrent_reg <= 1'b0;
    end else begin
      if (thermal_trip_i) begin
        thermal_reg <= 1'b1;
      end else if (!standby_n_i) begin
        thermal_reg <= 1'b0;
      end
      if (overcurrent_trip_i) begin
        overcurrent_reg <= 1'b1;
      end else if (!standby_n_i) begin
        overcurrent_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    // Run only when awake, fault free and enabled
    assign run[ch] = standby_n_i && !thermal_reg && !overcurrent_reg && ctrl_reg[ch];

    hcd_chop_chan #(
      .BLANK_CYC(BLANK_CYC)
    ) u_chan (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .run_i(run[ch]),
      .osc_tick_i(osc_tick_reg),
      .phase_i(phase_i[ch]),
      .cur_hit_i(current_limit_threshold_i[ch]),
      .high_side_one_o(high_side_one_o[ch]),
      .low_side_one_o(low_side_one_o[ch]),
      .high_side_two_o(high_side_two_o[ch]),
      .low_side_two_o(low_side_two_o[ch]),
      .hit_o(hit[ch]),
      .mode_o(mode[ch])
    );
  end

  // ****************************************
  // Write channel
  // ****************************************
  assign aw_have = !s_axi_awready_o && !s_axi_bvalid_o;
  assign w_have = !s_axi_wready_o && !s_axi_bvalid_o;
  assign wr_fire = aw_have && w_have;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_axi_awready_o <= 1'b1;
      aw_addr_reg <= 5'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_axi_wready_o <= 1'b1;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= known_addr(aw_addr_reg) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= CTRL_RESET;
      irq_en_reg <= IRQ_EN_RESET;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg == REG_CTRL) begin
        ctrl_reg <= w_data_reg[1:0];
      end
      if (aw_addr_reg == REG_IRQ_EN) begin
        irq_en_reg <= w_data_reg[3:0];
      end
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  assign irq_clr = (wr_fire && aw_addr_reg == REG_IRQ_CLR) ?
                   low_nibble(w_data_reg, w_strb_reg) : 4'h0;
  assign irq_set = {hit[1], hit[0], overcurrent_trip_i, thermal_trip_i};

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_stat_reg <= 4'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= known_addr(s_axi_araddr_i) ? RESP_OKAY : RESP_DECERR;
      unique case (s_axi_araddr_i)
        REG_CTRL: s_axi_rdata_o <= {30'h0, ctrl_reg};
        REG_STATUS: s_axi_rdata_o <= {25'h0, mode[1], mode[0], !standby_n_i,
                                      overcurrent_reg, thermal_reg};
        REG_IRQ_STAT: s_axi_rdata_o <= {28'h0, irq_stat_reg};
        REG_IRQ_EN: s_axi_rdata_o <= {28'h0, irq_en_reg};
        default: s_axi_rdata_o <= 32'h0;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: hcd_pkg.sv
package hcd_pkg;

  // ****************************************
  // Clock and oscillator
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int OSC_HZ = 1_600_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [3:0] OSC_DIV_LAST = 4'(OSC_DIV - 1);

  // ****************************************
  // Chop period and decay timing
  // ****************************************
  localparam int CHOP_DIV = 16;
  localparam logic [3:0] CHOP_LAST = 4'(CHOP_DIV - 1);
  localparam int MIX_PERMILLE = 375;
  localparam logic [3:0] MIX_POINT = 4'((CHOP_DIV * MIX_PERMILLE) / 1000);
  localparam int BLANK_NS = 400;
  localparam int BLANK_CYCLES = (BLANK_NS * CLK_MHZ) / 1000;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_EN = 5'h0c;
  localparam logic [4:0] REG_IRQ_CLR = 5'h10;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  localparam int IRQ_THERMAL = 0;
  localparam int IRQ_OVERCURRENT = 1;
  localparam int IRQ_HIT_A = 2;
  localparam int IRQ_HIT_B = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // Bridge modes
  // ****************************************
  typedef enum logic [1:0] {
    HCD_OFF = 2'h0,
    HCD_CHARGE = 2'h1,
    HCD_SLOW = 2'h3,
    HCD_FAST = 2'h2
  } hcd_mode_t;

  // Switch pattern {high_side_one, low_side_one, high_side_two, low_side_two}
  function automatic logic [3:0] hcd_bridge(input hcd_mode_t mode, input logic phase);
    logic [3:0] sw;
    sw = 4'h0;
    unique case (mode)
      HCD_CHARGE: sw = phase ? 4'h9 : 4'h6;
      HCD_SLOW: sw = 4'h5;
      HCD_FAST: sw = phase ? 4'h6 : 4'h9;
      HCD_OFF: sw = 4'h0;
    endcase
    return sw;
  endfunction

endpackage

// File: hcd_chop_chan.sv
`timescale 1ns/100ps
`default_nettype none
module hcd_chop_chan import hcd_pkg::*; #(
  parameter int BLANK_CYC = BLANK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic osc_tick_i,
  input wire logic phase_i,
  input wire logic cur_hit_i,
  output logic high_side_one_o,
  output logic low_side_one_o,
  output logic high_side_two_o,
  output logic low_side_two_o,
  output logic hit_o,
  output logic [1:0] mode_o
);

  hcd_mode_t mode_reg;
  logic [3:0] cnt_reg;
  logic [3:0] blank_reg;
  logic period_end;
  logic [3:0] sw;

  assign period_end = osc_tick_i && (cnt_reg == CHOP_LAST);
  assign sw = hcd_bridge(mode_reg, phase_i);
  assign mode_o = mode_reg;

  // ****************************************
  // Oscillator cycle count and blanking
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !run_i) begin
      cnt_reg <= 4'h0;
      blank_reg <= 4'h0;
    end else if (mode_reg == HCD_OFF || period_end) begin
      cnt_reg <= 4'h0;
      blank_reg <= 4'(BLANK_CYC);
    end else begin
      if (osc_tick_i) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
      if (blank_reg != 4'h0) begin
        blank_reg <= blank_reg - 4'h1;
      end
    end
  end

  // ****************************************
  // Decay sequence
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !run_i) begin
      mode_reg <= HCD_OFF;
      hit_o <= 1'b0;
    end else begin
      hit_o <= 1'b0;
      if (mode_reg == HCD_OFF || period_end) begin
        mode_reg <= HCD_CHARGE;
      end else begin
        unique case (mode_reg)
          HCD_CHARGE: begin
            if (blank_reg == 4'h0 && cur_hit_i) begin
              hit_o <= 1'b1;
              mode_reg <= (cnt_reg < MIX_POINT) ? HCD_SLOW : HCD_FAST;
            end
          end
          HCD_SLOW: begin
            if (osc_tick_i && cnt_reg == MIX_POINT - 4'h1) begin
              mode_reg <= HCD_FAST;
            end
          end
          HCD_FAST, HCD_OFF: begin
            mode_reg <= mode_reg;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Switch drive
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !run_i) begin
      {high_side_one_o, low_side_one_o, high_side_two_o, low_side_two_o} <= 4'h0;
    end else begin
      {high_side_one_o, low_side_one_o, high_side_two_o, low_side_two_o} <= sw;
    end
  end

endmodule
`default_nettype wire

// File: hcd_chk.sv
`timescale 1ns/100ps
`default_nettype none
module hcd_chk #(
  parameter int OSC_DIVIDE = 12
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic standby_n_i,
  input wire logic thermal_trip_i,
  input wire logic overcurrent_trip_i,
  input wire logic [1:0] phase_i,
  input wire logic [1:0] high_side_one_o,
  input wire logic [1:0] low_side_one_o,
  input wire logic [1:0] high_side_two_o,
  input wire logic [1:0] low_side_two_o
);
  // ********
  // Channel A decode
  // ********
  localparam int PER = 16 * OSC_DIVIDE;
  localparam int MIXC = 6 * OSC_DIVIDE;
  logic [9:0] cnt_reg;
  logic ph_chg_reg;
  wire logic [3:0] sw = {high_side_one_o[0], low_side_one_o[0], high_side_two_o[0],
      low_side_two_o[0]};
  wire logic chg = sw == (phase_i[0] ? 4'h9 : 4'h6);
  wire logic fst = sw == (phase_i[0] ? 4'h6 : 4'h9);
  wire logic slw = sw == 4'h5;
  wire logic off = {high_side_one_o, low_side_one_o, high_side_two_o, low_side_two_o} == 8'h0;
  wire logic ok = standby_n_i && !thermal_trip_i && !overcurrent_trip_i;
  // Switches lag a direction change by one cycle
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ph_chg_reg <= 1'b0;
    end else begin
      ph_chg_reg <= $changed(phase_i);
    end
  end
  // Cycles since charge began, zero while unknown
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || !ok || sw == 4'h0 || $changed(phase_i) || ph_chg_reg) begin
      cnt_reg <= 10'h0;
    end else if ($rose(chg)) begin
      cnt_reg <= 10'h1;
    end else if (cnt_reg != 10'h0) begin
      cnt_reg <= cnt_reg + 10'h1;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_no_shoot: assert property (
    ((high_side_one_o & low_side_one_o) | (high_side_two_o & low_side_two_o)) == 2'h0
  ) else $error("bridge leg shorted");
  a_thermal_off: assert property (
    thermal_trip_i && standby_n_i ##1 standby_n_i [*8] |-> off
  ) else $error("switches on after thermal trip");
  a_overcur_off: assert property (
    overcurrent_trip_i && standby_n_i ##1 standby_n_i [*8] |-> off
  ) else $error("switches on after overcurrent trip");
  a_standby_off: assert property (!standby_n_i [*4] |-> off)
    else $error("switches on in standby");
  a_blank_hold: assert property (
    $rose(chg) && $stable(phase_i) && !ph_chg_reg |=> chg || off || !$stable(phase_i)
  ) else $error("charge left inside blank window");
  a_period_len: assert property (
    $rose(chg) && cnt_reg != 10'h0 && $stable(phase_i) && !ph_chg_reg |-> cnt_reg == 10'(PER)
  ) else $error("chop period length wrong");
  a_mix_point: assert property (
    $rose(fst) && $past(slw) && cnt_reg != 10'h0 && $stable(phase_i) && !ph_chg_reg
      |-> cnt_reg == 10'(MIXC)
  ) else $error("slow to fast not at mixed point");
  a_late_fast: assert property (
    $rose(fst) && $past(chg) && cnt_reg != 10'h0 && $stable(phase_i) && !ph_chg_reg
      |-> cnt_reg >= 10'(MIXC)
  ) else $error("fast decay before mixed point");
  a_fast_rest: assert property (fst ##1 !fst && $stable(phase_i) |-> !slw)
    else $error("fast decay left for slow");
  a_slow_fast: assert property (slw ##1 !slw && $stable(phase_i) |-> fst || off)
    else $error("slow decay not followed by fast");
  c_early: cover property ($rose(fst) && $past(slw));
  c_late: cover property ($rose(fst) && $past(chg));
  c_trip: cover property (thermal_trip_i ##2 off);
endmodule
bind hcd_top hcd_chk #(.OSC_DIVIDE(OSC_DIVIDE)) u_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .standby_n_i(standby_n_i),
  .thermal_trip_i(thermal_trip_i), .overcurrent_trip_i(overcurrent_trip_i), .phase_i(phase_i),
  .high_side_one_o(high_side_one_o), .low_side_one_o(low_side_one_o),
  .high_side_two_o(high_side_two_o), .low_side_two_o(low_side_two_o)
);
`default_nettype wire

// File: hcd_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
module hcd_motor_model (
  input wire logic ref_clk_i,
  input wire logic [1:0] phase_i,
  input wire logic [1:0] high_side_one_i,
  input wire logic [1:0] low_side_one_i,
  input wire logic [1:0] high_side_two_i,
  input wire logic [1:0] low_side_two_i,
  input wire logic [7:0] limit_a_i,
  input wire logic [7:0] limit_b_i,
  output logic [1:0] current_limit_threshold_o
);
  // ********
  // Winding current along the commanded direction
  // ********
  int mag_reg [2];
  logic [1:0] fwd;
  logic [1:0] rev;
  logic [1:0] pos;
  logic [1:0] neg;
  assign pos = high_side_one_i & low_side_two_i;
  assign neg = low_side_one_i & high_side_two_i;
  assign fwd = (phase_i & pos) | (~phase_i & neg);
  assign rev = (phase_i & neg) | (~phase_i & pos);
  // Saturates in charge, reverse drive drains faster than recirculation
  always_ff @(posedge ref_clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (fwd[c]) begin
        mag_reg[c] <= (mag_reg[c] > 96) ? 100 : mag_reg[c] + 3;
      end else begin
        mag_reg[c] <= (mag_reg[c] > (rev[c] ? 5 : 1)) ? mag_reg[c] - (rev[c] ? 5 : 1) : 0;
      end
    end
  end
  assign current_limit_threshold_o = {mag_reg[1] >= int'(limit_b_i), mag_reg[0] >= int'(limit_a_i)};
endmodule
`default_nettype wire

// File: hcd_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module hcd_top_tb;
  import hcd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] awaddr = 5'h0;
  logic [4:0] araddr = 5'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic stby_n = 1'b1;
  logic therm = 1'b0;
  logic ovc = 1'b0;
  logic [1:0] phase = 2'h3;
  logic [7:0] lim_a = 8'hff;
  logic [7:0] lim_b = 8'hff;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, thr, hs1, ls1, hs2, ls2;
  logic [31:0] rdata;
  int n_fail = 0;
  int total_checks = 0;
  initial forever #25 clk = ~clk;
  hcd_top #(.OSC_DIVIDE(2), .BLANK_CYC(2)) dut (
    .ref_clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
    .standby_n_i(stby_n), .thermal_trip_i(therm), .overcurrent_trip_i(ovc), .phase_i(phase),
    .current_limit_threshold_i(thr), .high_side_one_o(hs1), .low_side_one_o(ls1),
    .high_side_two_o(hs2), .low_side_two_o(ls2), .irq_o(irq)
  );
  hcd_motor_model u_mot (
    .ref_clk_i(clk), .phase_i(phase), .high_side_one_i(hs1), .low_side_one_i(ls1),
    .high_side_two_i(hs2), .low_side_two_i(ls2), .limit_a_i(lim_a), .limit_b_i(lim_b),
    .current_limit_threshold_o(thr)
  );
  // ********
  // Checking and bus helpers
  // ********
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic lost(input string n);
    n_fail++;
    $display("mismatch %s expected answer seen timeout", n);
    complete_run;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 100) lost("bvalid");
    chk("bresp", 32'(bresp), 32'(er));
  endtask
  task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] e,
      input logic [1:0] er);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 100) lost("rvalid");
    chk("rresp", 32'(rresp), 32'(er));
    if (er == RESP_OKAY) chk(n, rdata, e);
  endtask
  function automatic logic [3:0] sw(input int c);
    return {hs1[c], ls1[c], hs2[c], ls2[c]};
  endfunction
  task automatic wait_sw(input int c, input logic [3:0] e);
    int i;
    for (i = 0; i < 400 && sw(c) !== e; i++) @(posedge clk);
    if (i == 400) lost("sync");
  endtask
  task automatic next_sw(input int c, input string n, input logic [3:0] e);
    logic [3:0] p;
    int i;
    p = sw(c);
    for (i = 0; i < 400 && sw(c) === p; i++) @(posedge clk);
    if (i == 400) lost(n);
    chk(n, 32'(sw(c)), 32'(e));
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rchk("ctrl reset", REG_CTRL, 32'(CTRL_RESET), RESP_OKAY);
    rchk("irq_en reset", REG_IRQ_EN, 32'(IRQ_EN_RESET), RESP_OKAY);
    rchk("unmapped read", 5'h14, 32'h0, RESP_DECERR);
    wr(5'h18, 32'h1, RESP_DECERR);
    wr(REG_IRQ_EN, 32'h5, RESP_OKAY);
    rchk("irq_en", REG_IRQ_EN, 32'h5, RESP_OKAY);
  endtask
  task automatic t_decay(input logic ph, input logic [7:0] lim);
    logic [3:0] c_p;
    logic [3:0] f_p;
    c_p = ph ? 4'h9 : 4'h6;
    f_p = ph ? 4'h6 : 4'h9;
    phase <= {ph, ph};
    lim_a <= lim;
    lim_b <= lim;
    // Two chop periods to shed the old direction
    repeat (70) @(posedge clk);
    for (int c = 0; c < 2; c++) begin
      wait_sw(c, f_p);
      chk("sync", 32'(sw(c)), 32'(f_p));
      next_sw(c, "charge", c_p);
      if (lim < 8'd30) next_sw(c, "early slow", 4'h5);
      next_sw(c, "fast", f_p);
      next_sw(c, "restart", c_p);
    end
  endtask
  task automatic t_irq;
    int i;
    // Channel B quiet so only the A hit is latched
    lim_a <= 8'd20;
    lim_b <= 8'hff;
    wr(REG_IRQ_CLR, 32'hf, RESP_OKAY);
    wr(REG_IRQ_EN, 32'h4, RESP_OKAY);
    for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
    if (i == 400) lost("irq");
    wr(REG_IRQ_EN, 32'h0, RESP_OKAY);
    @(posedge clk);
    chk("irq masked", 32'(irq), 32'h0);
    rchk("hit latched", REG_IRQ_STAT, 32'h4, RESP_OKAY);
    lim_a <= 8'hff;
    lim_b <= 8'hff;
    repeat (70) @(posedge clk);
    wr(REG_IRQ_CLR, 32'hf, RESP_OKAY);
    wr(REG_IRQ_EN, 32'h4, RESP_OKAY);
    @(posedge clk);
    chk("irq cleared", 32'(irq), 32'h0);
    rchk("stat cleared", REG_IRQ_STAT, 32'h0, RESP_OKAY);
  endtask
  task automatic t_fault(input int k);
    wr(REG_IRQ_CLR, 32'hf, RESP_OKAY);
    wr(REG_IRQ_EN, 32'h3, RESP_OKAY);
    lim_a <= 8'd20;
    lim_b <= 8'd20;
    therm <= (k == 0);
    ovc <= (k == 1);
    @(posedge clk);
    therm <= 1'b0;
    ovc <= 1'b0;
    repeat (80) @(posedge clk);
    chk("off after trip", {hs1, ls1, hs2, ls2}, 32'h0);
    chk("trip irq", 32'(irq), 32'h1);
    rchk("trip status", REG_STATUS, 32'h1 << k, RESP_OKAY);
    stby_n <= 1'b0;
    repeat (4) @(posedge clk);
    rchk("standby status", REG_STATUS, 32'h4, RESP_OKAY);
    chk("off in standby", {hs1, ls1, hs2, ls2}, 32'h0);
    stby_n <= 1'b1;
    next_sw(0, "resume", phase[0] ? 4'h9 : 4'h6);
  endtask
  task automatic t_ctrl;
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk("channel a off", 32'(sw(0)), 32'h0);
    rchk("ctrl", REG_CTRL, 32'h2, RESP_OKAY);
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    next_sw(0, "channel a on", phase[0] ? 4'h9 : 4'h6);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_decay(1'b1, 8'd20);
    t_decay(1'b0, 8'd45);
    t_irq;
    t_fault(0);
    t_fault(1);
    t_ctrl;
    complete_run;
  end
endmodule
`default_nettype wire
